// file: common/fsp_map.vh
// constants of the flash status polling controller
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// clock and bus timing
`define FSP_CLK_NS        10
`define FSP_T_ACC_NS      70
`define FSP_T_WP_NS       35
`define FSP_ACC_CYC       ((`FSP_T_ACC_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WP_CYC        ((`FSP_T_WP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SYNC_CYC      2
`define FSP_RD_HOLD       (`FSP_ACC_CYC + `FSP_SYNC_CYC)

// status bit positions on the data bus
`define FSP_POLL_BIT      7
`define FSP_TOG_BIT       6
`define FSP_TMO_BIT       5
`define FSP_SEC_BIT       2

// polling methods
`define FSP_M_DATA        2'h0
`define FSP_M_TOG         2'h1
`define FSP_M_SEC         2'h2
`define FSP_M_RB          2'h3

// reset command and reset values
`define FSP_RESET_CMD     8'hf0
`define FSP_ADDR_W        20
`define FSP_ADDR_RST      20'h00000
`define FSP_DATA_RST      8'h00

`endif

// file: src/fsp_cycle.v
// single asynchronous read or write cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.vh"

module fsp_cycle
(
    // clock and reset
    input  wire                    mclk,
    input  wire                    rst_n,
    // cycle request
    input  wire                    req,
    input  wire                    wr,
    input  wire [`FSP_ADDR_W-1:0]  addr,
    input  wire [7:0]              wdata,
    output reg                     ack_q,
    output reg  [7:0]              rdata_q,
    output reg                     idle_q,
    // flash pins
    output reg  [`FSP_ADDR_W-1:0]  flash_addr_q,
    output reg                     flash_ce_n_q,
    output reg                     flash_oe_n_q,
    output reg                     flash_we_n_q,
    output reg  [7:0]              flash_dq_o_q,
    output reg                     flash_dq_oe_q,
    input  wire [7:0]              flash_dq_i
);

    localparam [1:0] C_IDLE = 2'h0;
    localparam [1:0] C_STRB = 2'h1;
    localparam [1:0] C_REC  = 2'h2;

    // strobe lengths as counter loads, cut to the counter width on purpose
    localparam [31:0] WP_LOAD_W = `FSP_WP_CYC - 1;
    localparam [31:0] RD_LOAD_W = `FSP_RD_HOLD - 1;
    localparam [3:0]  WP_LOAD   = WP_LOAD_W[3:0];
    localparam [3:0]  RD_LOAD   = RD_LOAD_W[3:0];

    reg [1:0] st_q;
    reg [3:0] cnt_q;
    reg       wr_q;
    reg [7:0] dq_s1_q;
    reg [7:0] dq_s2_q;

    // two-flop synchroniser on the data pins
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end
        else
        begin
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // strobe sequencer; one recovery cycle frames each read apart
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q          <= C_IDLE;
            cnt_q         <= 4'h0;
            wr_q          <= 1'b0;
            ack_q         <= 1'b0;
            idle_q        <= 1'b1;
            rdata_q       <= `FSP_DATA_RST;
            flash_addr_q  <= `FSP_ADDR_RST;
            flash_ce_n_q  <= 1'b1;
            flash_oe_n_q  <= 1'b1;
            flash_we_n_q  <= 1'b1;
            flash_dq_o_q  <= `FSP_DATA_RST;
            flash_dq_oe_q <= 1'b0;
        end
        else
        begin
            ack_q <= 1'b0;
            case (st_q)
                C_IDLE:
                begin
                    if (req)
                    begin
                        st_q          <= C_STRB;
                        idle_q        <= 1'b0;
                        wr_q          <= wr;
                        flash_addr_q  <= addr;
                        flash_ce_n_q  <= 1'b0;
                        flash_oe_n_q  <= wr;
                        flash_we_n_q  <= ~wr;
                        flash_dq_o_q  <= wdata;
                        flash_dq_oe_q <= wr;
                        cnt_q         <= wr ? WP_LOAD : RD_LOAD;
                    end
                end
                C_STRB:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        st_q         <= C_REC;
                        flash_ce_n_q <= 1'b1;
                        flash_oe_n_q <= 1'b1;
                        flash_we_n_q <= 1'b1;
                        if (!wr_q)
                            rdata_q <= dq_s2_q;  // data seen at least access time after strobe
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                C_REC:
                begin
                    st_q          <= C_IDLE;
                    flash_dq_oe_q <= 1'b0;  // data held one cycle past write strobe
                    ack_q         <= 1'b1;
                    idle_q        <= 1'b1;
                end
                default:
                    st_q <= C_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: src/fsp_poll_ctrl.v
// host-side controller that polls embedded program/erase status of a nor flash
//
// Contract
// R01: device inverts poll bit while programming
// R02: poll at the address being programmed
// R03: protected program target shows status briefly
// R04: poll bit low during erase, high after
// R05: sector erase polls inside an erasing sector
// R06: all-protected erase shows status about 100us
// R07: protected sector address may give invalid status
// R08: poll bit may settle before lower bits
// R09: status valid after final write strobe rises
// R10: ready/busy is an open-drain shared line
// R11: ready/busy low while programming or erasing
// R12: any-address toggle bit flips each read
// R13: toggle runs in time-out, stops in suspend
// R14: protected targets toggle briefly, then array
// R15: toggle continues for program in suspend
// R16: sector toggle flips in erase-selected sectors
// R17: two reads, unchanged toggle means done
// R18: timeout with toggling: retest, then reset command
// R19: returning to polling restarts from first step
// R20: reread poll bit after timeout flag seen
// R21: chip erase polls any unprotected sector
// R22: device raises timeout flag on failure
// R23: status only from the busy bank
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.vh"

module fsp_poll_ctrl
(
    // clock and reset
    input  wire                    mclk,
    input  wire                    rst_n,
    // user orders
    input  wire                    start,
    input  wire [1:0]              method,
    input  wire                    is_erase,
    input  wire [`FSP_ADDR_W-1:0]  poll_addr,
    input  wire [7:0]              prog_data,
    input  wire                    abandon,
    // user results
    output reg                     busy_q,
    output reg                     done_q,
    output reg                     pass_q,
    output reg                     fail_q,
    output reg  [7:0]              last_status_q,
    output reg                     ready_q,
    // flash pins
    output wire [`FSP_ADDR_W-1:0]  flash_addr,
    output wire                    flash_ce_n,
    output wire                    flash_oe_n,
    output wire                    flash_we_n,
    output wire [7:0]              flash_dq_o,
    output wire                    flash_dq_oe,
    input  wire [7:0]              flash_dq_i,
    input  wire                    ready_busy_n
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_READ = 3'h1;
    localparam [2:0] S_WAIT = 3'h2;
    localparam [2:0] S_EVAL = 3'h3;
    localparam [2:0] S_RST  = 3'h4;
    localparam [2:0] S_RSTW = 3'h5;
    localparam [2:0] S_RB   = 3'h6;

    reg [2:0]              st_q;
    reg [1:0]              method_q;
    reg [`FSP_ADDR_W-1:0]  addr_q;
    reg                    expect_q;
    reg                    have_prev_q;
    reg                    prev_q;
    reg                    tmo_seen_q;
    reg                    abandon_q;
    reg                    req_q;
    reg                    wr_q;
    reg                    rb_s1_q;
    reg                    rb_s2_q;
    wire                   cyc_ack;
    wire [7:0]             cyc_rdata;
    wire                   cyc_idle;
    wire                   cur_tog;

    // picks the toggle bit that the chosen method watches
    function tog_pick;
        input [1:0] m;
        input [7:0] d;
        begin
            tog_pick = (m == `FSP_M_SEC) ? d[`FSP_SEC_BIT] : d[`FSP_TOG_BIT];
        end
    endfunction

    assign cur_tog = tog_pick(method_q, cyc_rdata);

    // bus cycle engine on the flash pins
    fsp_cycle u_cycle
    (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .req           (req_q),
        .wr            (wr_q),
        .addr          (addr_q),
        .wdata         (`FSP_RESET_CMD),
        .ack_q         (cyc_ack),
        .rdata_q       (cyc_rdata),
        .idle_q        (cyc_idle),
        .flash_addr_q  (flash_addr),
        .flash_ce_n_q  (flash_ce_n),
        .flash_oe_n_q  (flash_oe_n),
        .flash_we_n_q  (flash_we_n),
        .flash_dq_o_q  (flash_dq_o),
        .flash_dq_oe_q (flash_dq_oe),
        .flash_dq_i    (flash_dq_i)
    );

    // open-drain ready/busy line is sampled through two flops
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            ready_q <= 1'b1;
        end
        else
        begin
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
            ready_q <= rb_s2_q;
        end
    end

    // polling sequencer
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q          <= S_IDLE;
            method_q      <= `FSP_M_DATA;
            addr_q        <= `FSP_ADDR_RST;
            expect_q      <= 1'b0;
            have_prev_q   <= 1'b0;
            prev_q        <= 1'b0;
            tmo_seen_q    <= 1'b0;
            abandon_q     <= 1'b0;
            req_q         <= 1'b0;
            wr_q          <= 1'b0;
            busy_q        <= 1'b0;
            done_q        <= 1'b0;
            pass_q        <= 1'b0;
            fail_q        <= 1'b0;
            last_status_q <= `FSP_DATA_RST;
        end
        else
        begin
            req_q  <= 1'b0;
            done_q <= 1'b0;
            if (abandon && busy_q)
                abandon_q <= 1'b1;
            case (st_q)
                S_IDLE:
                begin
                    abandon_q <= 1'b0;
                    if (start && cyc_idle)
                    begin
                        // R19: every start begins the procedure afresh
                        have_prev_q <= 1'b0;
                        tmo_seen_q  <= 1'b0;
                        // R02 R05 R21: caller gives the valid poll address
                        addr_q      <= poll_addr;
                        method_q    <= method;
                        // R04: erase completes with the poll bit high
                        expect_q    <= is_erase ? 1'b1 : prog_data[`FSP_POLL_BIT];
                        busy_q      <= 1'b1;
                        pass_q      <= 1'b0;
                        fail_q      <= 1'b0;
                        st_q        <= (method == `FSP_M_RB) ? S_RB : S_READ;
                    end
                end
                S_READ:
                begin
                    req_q <= 1'b1;
                    wr_q  <= 1'b0;
                    st_q  <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (cyc_ack)
                    begin
                        last_status_q <= cyc_rdata;
                        st_q          <= abandon_q ? S_IDLE : S_EVAL;
                        if (abandon_q)
                            busy_q <= 1'b0;
                    end
                end
                S_EVAL:
                begin
                    st_q <= S_READ;
                    if (method_q == `FSP_M_DATA)
                    begin
                        // R01: true bit 7 seen means programming done
                        if (cyc_rdata[`FSP_POLL_BIT] == expect_q)
                        begin
                            pass_q <= 1'b1;
                            done_q <= 1'b1;
                            busy_q <= 1'b0;
                            st_q   <= S_IDLE;
                        end
                        // R20: one more poll read after the timeout flag
                        else if (tmo_seen_q)
                            st_q <= S_RST;
                        else if (cyc_rdata[`FSP_TMO_BIT])
                            tmo_seen_q <= 1'b1;
                    end
                    else
                    begin
                        prev_q      <= cur_tog;
                        have_prev_q <= 1'b1;
                        // R17: unchanged toggle between two reads means done
                        if (have_prev_q && (cur_tog == prev_q))
                        begin
                            pass_q <= 1'b1;
                            done_q <= 1'b1;
                            busy_q <= 1'b0;
                            st_q   <= S_IDLE;
                        end
                        // R18: still toggling after timeout seen fails
                        else if (have_prev_q && tmo_seen_q)
                            st_q <= S_RST;
                        else if (have_prev_q && cyc_rdata[`FSP_TMO_BIT])
                            tmo_seen_q <= 1'b1;
                    end
                end
                S_RST:
                begin
                    // R18: failed operation needs the reset command
                    req_q <= 1'b1;
                    wr_q  <= 1'b1;
                    st_q  <= S_RSTW;
                end
                S_RSTW:
                begin
                    if (cyc_ack)
                    begin
                        fail_q <= 1'b1;
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        st_q   <= S_IDLE;
                    end
                end
                S_RB:
                begin
                    // R11: wait for the shared line to be released
                    if (rb_s2_q || abandon_q)
                    begin
                        pass_q <= ~abandon_q;
                        done_q <= ~abandon_q;
                        busy_q <= 1'b0;
                        st_q   <= S_IDLE;
                    end
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: sim/fsp_poll_ctrl_monitor.sv
// port assertions for the flash status polling controller
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.vh"
module fsp_poll_ctrl_monitor
(
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst_n,
    // user side
    input wire logic                   busy_q,
    input wire logic                   done_q,
    input wire logic                   pass_q,
    input wire logic                   fail_q,
    input wire logic [`FSP_ADDR_W-1:0] poll_addr,
    // flash pins
    input wire logic [`FSP_ADDR_W-1:0] flash_addr,
    input wire logic                   flash_ce_n,
    input wire logic                   flash_oe_n,
    input wire logic                   flash_we_n,
    input wire logic [7:0]             flash_dq_o,
    input wire logic                   flash_dq_oe
);
    logic [3:0] rd_len = 4'h0;
    // consecutive cycles with the read strobe low
    always @(posedge mclk)
        rd_len <= flash_oe_n ? 4'h0 : rd_len + 4'h1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // strobes, data drive and address
    a_no_rd_wr: assert property (!(!flash_oe_n && !flash_we_n))
        else $error("read and write strobes low together");
    a_dq_oe_read: assert property (flash_dq_oe |-> flash_oe_n)
        else $error("data driven during a read");
    a_read_hold: assert property ($rose(flash_oe_n) |-> rd_len == 4'(`FSP_RD_HOLD))
        else $error("read strobe length wrong");
    a_write_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
        else $error("write strobe length wrong");
    a_write_data: assert property (!flash_we_n |-> flash_dq_oe && flash_dq_o == `FSP_RESET_CMD)
        else $error("write is not the reset command");
    a_addr_poll: assert property (!flash_ce_n |-> flash_addr == poll_addr)
        else $error("cycle not at the poll address");
    // results
    a_result_done: assert property ($rose(pass_q) || $rose(fail_q) |-> done_q)
        else $error("result without done");
    a_done_one: assert property (done_q |-> pass_q != fail_q ##1 !done_q)
        else $error("done not a single pulse with one result");
    a_done_busy: assert property (done_q |-> !busy_q && $past(busy_q))
        else $error("done without busy ending");
    a_write_fail: assert property ($fell(flash_we_n) |-> ##[1:10] done_q && fail_q)
        else $error("reset write not followed by failure");
    c_pass: cover property (done_q && pass_q);
    c_fail: cover property (done_q && fail_q);
    c_write: cover property ($fell(flash_we_n));
endmodule
`default_nettype wire

// file: sim/fsp_flash_model.sv
// behavioural flash answering status reads
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model
(
    // clock and scenario
    input wire logic        mclk,
    input wire logic        arm,
    input wire logic        erase,
    input wire logic        stuck,
    input wire logic [7:0]  pdata,
    input wire logic [7:0]  nrd,
    input wire logic [19:0] vaddr,
    input wire logic [19:0] addr,
    // flash pins
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        dq_oe,
    input wire logic [7:0]  dq_o,
    output logic     [7:0]  dq_i,
    output logic            rb_low,
    output wire logic       got_reset
);
    logic [7:0] cnt_q  = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic       tog_q  = 1'b0;
    logic       sec_q  = 1'b0;
    logic       sel_q  = 1'b0;
    logic       got_q  = 1'b0;
    logic [7:0] arr;
    logic [7:0] stat;
    logic       sel;
    logic       busy;
    logic       tmo;
    assign got_reset = got_q;
    // busy for a few reads, timeout and open-drain pull
    assign busy   = cnt_q < nrd && !got_q;
    assign tmo    = stuck && cnt_q >= 8'h02;
    assign rb_low = busy;
    assign sel    = !ce_n && !oe_n;
    // array data away from the busy address
    assign arr  = erase ? 8'hff : pdata;
    assign stat = (!busy || addr != vaddr) ? arr : {erase ? 1'b0 : ~pdata[7], tog_q, tmo,
                  pdata[4:3], erase ? sec_q : pdata[2], pdata[1:0]};
    // released bus shows the inverse of the last byte
    assign dq_i = sel ? stat : ~last_q;
    // toggles flip at the end of each busy read, the sector toggle only while erasing
    always @(posedge mclk)
    begin
        sel_q <= sel;
        if (sel)
            last_q <= stat;
        // status is valid as soon as the model is armed
        if (arm)
        begin
            cnt_q <= 8'h00;
            got_q <= 1'b0;
        end
        else if (sel_q && !sel)
        begin
            cnt_q <= cnt_q + 8'h01;
            tog_q <= tog_q ^ busy;
            sec_q <= sec_q ^ (busy && erase);
        end
        if (!we_n && !ce_n && dq_oe && dq_o == 8'hf0)
            got_q <= 1'b1;
    end
endmodule
`default_nettype wire

// file: sim/flash_write_status_reporting_bench.sv
// testbench of the flash status polling controller
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.vh"
module flash_write_status_reporting_bench;
    logic                   mclk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   start = 1'b0;
    logic [1:0]             method = 2'h0;
    logic                   is_erase = 1'b0;
    logic [`FSP_ADDR_W-1:0] poll_addr = 20'h0a5c3;
    logic [7:0]             prog_data = 8'h00;
    logic                   abandon = 1'b0;
    logic                   arm = 1'b1;
    logic                   stuck = 1'b0;
    logic [7:0]             nrd = 8'h00;
    wire                    busy_q, done_q, pass_q, fail_q, ready_q;
    wire  [7:0]             last_status_q, dq_o, dq_i;
    wire  [`FSP_ADDR_W-1:0] f_addr;
    wire                    ce_n, oe_n, we_n, dq_oe, rb_low, got_reset;
    wire                    ready_busy_n = rb_low ? 1'b0 : 1'b1;
    integer                 fails = 0;
    integer                 tests_run = 0;
    integer                 dn = 0;
    integer                 i;
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (done_q === 1'b1) dn <= dn + 1;
    fsp_poll_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .start(start), .method(method),
        .is_erase(is_erase), .poll_addr(poll_addr), .prog_data(prog_data), .abandon(abandon),
        .busy_q(busy_q), .done_q(done_q), .pass_q(pass_q), .fail_q(fail_q),
        .last_status_q(last_status_q), .ready_q(ready_q), .flash_addr(f_addr),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .ready_busy_n(ready_busy_n));
    fsp_flash_model u_flash (.mclk(mclk), .arm(arm), .erase(is_erase), .stuck(stuck),
        .pdata(prog_data), .nrd(nrd), .vaddr(poll_addr), .addr(f_addr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_oe(dq_oe),
        .dq_o(dq_o), .dq_i(dq_i), .rb_low(rb_low), .got_reset(got_reset));
    // compare and report
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // arm the flash and start polling
    task automatic go(input logic [1:0] m, input logic e, input logic [7:0] pd,
                      input logic [7:0] n, input logic st);
        @(posedge mclk);
        method    <= m;
        is_erase  <= e;
        prog_data <= pd;
        nrd       <= n;
        stuck     <= st;
        arm       <= 1'b1;
        @(posedge mclk);
        arm   <= 1'b0;
        // let the ready line pass the host's two sync flops before start
        repeat (2) @(posedge mclk);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
    endtask
    task automatic wait_done();
        i = 0;
        while (done_q !== 1'b1 && i < 400)
        begin
            @(negedge mclk);
            i = i + 1;
        end
        chk("done", {7'h00, done_q}, 8'h01);
    endtask
    task automatic run(input logic [1:0] m, input logic e, input logic [7:0] pd,
                       input logic [7:0] n, input logic st, input logic ok);
        go(m, e, pd, n, st);
        wait_done();
        chk("pass", {7'h00, pass_q}, {7'h00, ok});
        chk("fail", {7'h00, fail_q}, {7'h00, !ok});
        chk("reset write", {7'h00, got_reset}, {7'h00, !ok});
        if (ok)
            chk("last status", last_status_q, e ? 8'hff : pd);
    endtask
    initial
    begin
        #300000;
        fails = fails + 1;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        run(`FSP_M_DATA, 1'b0, 8'h5a, 8'h03, 1'b0, 1'b1);
        run(`FSP_M_DATA, 1'b0, 8'ha5, 8'h03, 1'b0, 1'b1);
        run(`FSP_M_DATA, 1'b1, 8'h00, 8'h04, 1'b0, 1'b1);
        run(`FSP_M_TOG, 1'b0, 8'h3c, 8'h05, 1'b0, 1'b1);
        run(`FSP_M_TOG, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
        run(`FSP_M_SEC, 1'b1, 8'h00, 8'h04, 1'b0, 1'b1);
        run(`FSP_M_TOG, 1'b0, 8'h3c, 8'hff, 1'b1, 1'b0);
        run(`FSP_M_DATA, 1'b0, 8'h5a, 8'hff, 1'b1, 1'b0);
        go(`FSP_M_RB, 1'b0, 8'h77, 8'hff, 1'b0);
        repeat (40) @(negedge mclk);
        chk("busy on ready line", {7'h00, busy_q}, 8'h01);
        chk("ready low while busy", {7'h00, ready_q}, 8'h00);
        nrd <= 8'h00;
        wait_done();
        chk("pass on ready", {7'h00, pass_q}, 8'h01);
        chk("ready high when done", {7'h00, ready_q}, 8'h01);
        go(`FSP_M_TOG, 1'b0, 8'h11, 8'hff, 1'b0);
        repeat (30) @(posedge mclk);
        i = dn;
        abandon <= 1'b1;
        @(posedge mclk);
        abandon <= 1'b0;
        repeat (40) @(negedge mclk);
        chk("abandon idle", {7'h00, busy_q, ce_n}, 8'h01);
        chk("abandon no done", (dn == i) ? 8'h01 : 8'h00, 8'h01);
        run(`FSP_M_TOG, 1'b0, 8'h11, 8'h02, 1'b0, 1'b1);
        give_verdict();
    end
endmodule
bind fsp_poll_ctrl fsp_poll_ctrl_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .busy_q(busy_q),
    .done_q(done_q), .pass_q(pass_q), .fail_q(fail_q), .poll_addr(poll_addr),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
`default_nettype wire
